// *** include/pc_stack_pkg.sv ***
package pc_stack_pkg;

    // program counter and stack geometry
    localparam int PC_W        = 21;     // program counter width
    localparam int BYTE_W      = 8;      // byte view width
    localparam int UPPER_W     = 5;      // bits 20..16
    localparam int SP_W        = 5;      // stack pointer width
    localparam int STACK_DEPTH = 31;     // entries 1..31, zero is empty
    localparam int STATUS_W    = 5;      // status register width
    localparam int BANK_W      = 4;      // bank select width

    // field positions inside the program counter
    localparam int PC_HIGH_LSB  = 8;
    localparam int PC_UPPER_LSB = 16;

    // reset and step values
    localparam logic [PC_W-1:0] PC_RESET    = 21'h000000;
    localparam logic [PC_W-1:0] PC_STEP     = 21'h000002;
    localparam logic [SP_W-1:0] SP_EMPTY    = 5'h00;
    localparam logic [SP_W-1:0] SP_FULL     = 5'h1F;
    localparam logic [SP_W-1:0] SP_ONE      = 5'h01;
    localparam logic [PC_W-1:0] VEC_HIGH    = 21'h000008;
    localparam logic [PC_W-1:0] VEC_LOW     = 21'h000018;

    // sequencing operation requested by the decoder for this cycle
    typedef enum logic [3:0] {
        OP_NONE,        // hold
        OP_NEXT,        // sequential fetch
        OP_JUMP,        // goto or branch, direct load
        OP_CALL,        // call or relative call, push
        OP_RETURN,      // return or return-with-literal, pop
        OP_IRET,        // return from interrupt
        OP_IRQ,         // interrupt acknowledge or wake-up vectoring
        OP_EXT_LINK     // extended add/sub link return
    } seq_op_t;

    // processor context saved by the shadow stack
    typedef struct packed {
        logic [STATUS_W-1:0] status;
        logic [BYTE_W-1:0]   working_register;
        logic [BANK_W-1:0]   bank_select_register;
    } context_t;

    // decoder command for one cycle
    typedef struct packed {
        seq_op_t          op;
        logic             fast;          // fast option on call/return/return_from_interrupt
        logic             irq_high;      // vector to high priority address
        logic             ext_enable;    // extended instruction set enabled
        logic [PC_W-1:0]  target;        // direct load address
    } seq_cmd_t;

endpackage

// *** src/return_stack_ram.sv ***
// storage of the return address stack, entry zero never written
module return_stack_ram (
    input  wire logic                            mclk,
    input  wire logic                            wr_en,
    input  wire logic [pc_stack_pkg::SP_W-1:0]   wr_addr,
    input  wire logic [pc_stack_pkg::PC_W-1:0]   wr_data,
    input  wire logic [pc_stack_pkg::SP_W-1:0]   rd_addr,
    output logic      [pc_stack_pkg::PC_W-1:0]   rd_data
);

    // index zero exists only to keep the read mux a plain lookup
    logic [pc_stack_pkg::PC_W-1:0] mem [0:pc_stack_pkg::STACK_DEPTH];

    // write port, zero address refused
    always_ff @(posedge mclk) begin
        if (wr_en && (wr_addr != pc_stack_pkg::SP_EMPTY)) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // asynchronous read so the top entry is visible at once
    always_comb begin
        if (rd_addr == pc_stack_pkg::SP_EMPTY) begin
            rd_data = '0;
        end else begin
            rd_data = mem[rd_addr];
        end
    end

endmodule

// *** src/program_counter_return_stack.sv ***
// Function
// [R1] 21-bit fetch address with three byte views
// [R2] low byte read/write, high byte hidden
// [R3] upper byte hidden, loaded through latch
// [R4] low byte write loads latches into counter
// [R5] low byte read copies counter into latches
// [R6] bit zero forced zero, step by two
// [R7] calls, gotos, branches load counter directly
// [R8] 31 by 21 stack, 5-bit pointer
// [R9] push on call/irq, pop on returns
// [R10] push: increment pointer, then write entry
// [R11] pop: read entry, then decrement pointer
// [R12] reset clears pointer; zero means empty
// [R13] top-of-stack bytes and pointer accessible
// [R14] error with reset enable requests reset
// [R15] error without enable only sets flag
// [R16] error flags sticky until software or power-on
// [R17] shadow saves context on interrupt vectoring
// [R18] fast interrupt return restores context
// [R19] nested interrupt overwrites single shadow level
// [R20] fast call saves, fast return restores
// [R21] wake-up interrupt pushes then loads vector
// [R22] software masks interrupts during stack access
// [R23] full push and empty pop flagged
module program_counter_return_stack (
    input  wire logic                                mclk,
    input  wire logic                                rst,          // any device reset
    input  wire logic                                por,          // power-on reset, clears flags
    input  wire pc_stack_pkg::seq_cmd_t              cmd,          // decoder request
    input  wire pc_stack_pkg::context_t              context_in,   // live status/working/bank
    input  wire logic                                stack_error_reset_enable,
    // software access to the low byte and latches
    input  wire logic                                low_wr,
    input  wire logic                                low_rd,
    input  wire logic [pc_stack_pkg::BYTE_W-1:0]     low_wdata,
    input  wire logic                                lath_wr,
    input  wire logic                                latu_wr,
    input  wire logic [pc_stack_pkg::BYTE_W-1:0]     lat_wdata,
    // software access to the stack
    input  wire logic                                sp_wr,
    input  wire logic [pc_stack_pkg::SP_W-1:0]       sp_wdata,
    input  wire logic                                top_low_wr,
    input  wire logic                                top_high_wr,
    input  wire logic                                top_upper_wr,
    input  wire logic [pc_stack_pkg::BYTE_W-1:0]     top_wdata,
    input  wire logic                                full_clr,     // software clear
    input  wire logic                                unf_clr,      // software clear
    // outputs
    output logic      [pc_stack_pkg::PC_W-1:0]       fetch_addr,
    output logic      [pc_stack_pkg::BYTE_W-1:0]     prog_counter_low_byte,
    output logic      [pc_stack_pkg::BYTE_W-1:0]     high_byte_latch,
    output logic      [pc_stack_pkg::BYTE_W-1:0]     upper_byte_latch,
    output logic      [pc_stack_pkg::SP_W-1:0]       return_stack_pointer,
    output logic      [pc_stack_pkg::BYTE_W-1:0]     stack_top_low,
    output logic      [pc_stack_pkg::BYTE_W-1:0]     stack_top_high,
    output logic      [pc_stack_pkg::BYTE_W-1:0]     stack_top_upper,
    output logic                                     stack_full_flag,
    output logic                                     stack_underflow_flag,
    output logic                                     stack_reset_req,  // one-cycle device reset request
    output logic                                     context_restore,  // one-cycle restore strobe
    output pc_stack_pkg::context_t                   context_out
);

    // program counter state
    logic [pc_stack_pkg::PC_W-1:0]   pc_r;                 // full counter
    logic [pc_stack_pkg::PC_W-1:0]   pc_nxt;               // next counter
    logic [pc_stack_pkg::BYTE_W-1:0] lath_r;               // high byte latch
    logic [pc_stack_pkg::BYTE_W-1:0] latu_r;               // upper byte latch
    logic [pc_stack_pkg::SP_W-1:0]   sp_r;                 // stack pointer
    logic [pc_stack_pkg::SP_W-1:0]   sp_nxt;               // next stack pointer
    logic                            full_r;               // sticky full flag
    logic                            unf_r;                // sticky underflow flag
    logic                            rst_req_r;            // reset request pulse
    pc_stack_pkg::context_t          shadow_r;             // one-level shadow stack
    logic                            restore_r;            // restore strobe

    // stack storage ports
    logic                            ram_wr;               // entry write enable
    logic [pc_stack_pkg::SP_W-1:0]   ram_waddr;            // entry written
    logic [pc_stack_pkg::PC_W-1:0]   ram_wdata;            // data written
    logic [pc_stack_pkg::PC_W-1:0]   stack_top_entry;      // entry under pointer

    // decoded operation class
    logic                            is_push;              // call or interrupt
    logic                            is_pop;               // any return
    logic                            push_full;            // push with no room
    logic                            pop_empty;            // pop with nothing stacked
    logic                            fast_save;            // shadow capture
    logic                            fast_restore;         // shadow restore

    // pop classification, reused by the pointer, stack write and error flag paths
    function automatic logic pop_op(input pc_stack_pkg::seq_cmd_t c);
        pop_op = (c.op == pc_stack_pkg::OP_RETURN) || (c.op == pc_stack_pkg::OP_IRET) ||
                 ((c.op == pc_stack_pkg::OP_EXT_LINK) && c.ext_enable); // R9
    endfunction

    // push classification
    function automatic logic push_op(input pc_stack_pkg::seq_cmd_t c);
        push_op = (c.op == pc_stack_pkg::OP_CALL) || (c.op == pc_stack_pkg::OP_IRQ); // R9
    endfunction

    // operation decode
    always_comb begin
        is_push      = push_op(cmd);
        is_pop       = pop_op(cmd);
        push_full    = is_push && (sp_r == pc_stack_pkg::SP_FULL); // R23
        pop_empty    = is_pop && (sp_r == pc_stack_pkg::SP_EMPTY); // R23
        fast_save    = (cmd.op == pc_stack_pkg::OP_IRQ) ||
                       ((cmd.op == pc_stack_pkg::OP_CALL) && cmd.fast); // R17 R20
        fast_restore = ((cmd.op == pc_stack_pkg::OP_IRET) || (cmd.op == pc_stack_pkg::OP_RETURN)) &&
                       cmd.fast; // R18 R20
    end

    // next program counter; decoder ops take priority over a software low byte write
    always_comb begin
        pc_nxt = pc_r;
        unique case (cmd.op)
            pc_stack_pkg::OP_NONE:     pc_nxt = pc_r;
            pc_stack_pkg::OP_NEXT:     pc_nxt = pc_r + pc_stack_pkg::PC_STEP; // R6
            pc_stack_pkg::OP_JUMP:     pc_nxt = cmd.target; // R7
            pc_stack_pkg::OP_CALL:     pc_nxt = cmd.target; // R7
            pc_stack_pkg::OP_IRQ:      pc_nxt = cmd.irq_high ? pc_stack_pkg::VEC_HIGH
                                                             : pc_stack_pkg::VEC_LOW; // R21
            pc_stack_pkg::OP_RETURN,
            pc_stack_pkg::OP_IRET:     pc_nxt = stack_top_entry; // R11
            pc_stack_pkg::OP_EXT_LINK: pc_nxt = cmd.ext_enable ? stack_top_entry : pc_r + pc_stack_pkg::PC_STEP;
            default:                   pc_nxt = pc_r;
        endcase
        if (cmd.op == pc_stack_pkg::OP_NONE && low_wr) begin
            // latches land in the hidden bytes together with the new low byte
            pc_nxt = {latu_r[pc_stack_pkg::UPPER_W-1:0], lath_r, low_wdata}; // R4
        end
        pc_nxt[0] = 1'b0; // R6
    end

    // program counter register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pc_r <= pc_stack_pkg::PC_RESET;
        end else begin
            pc_r <= pc_nxt; // R1
        end
    end

    // latch registers; only software writes and low byte reads touch them, never calls or returns
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lath_r <= '0;
            latu_r <= '0;
        end else if (low_rd) begin
            lath_r <= pc_r[pc_stack_pkg::PC_UPPER_LSB-1:pc_stack_pkg::PC_HIGH_LSB]; // R5
            latu_r <= {3'h0, pc_r[pc_stack_pkg::PC_W-1:pc_stack_pkg::PC_UPPER_LSB]}; // R5 R3
        end else begin
            if (lath_wr) begin
                lath_r <= lat_wdata;
            end
            if (latu_wr) begin
                latu_r <= {3'h0, lat_wdata[pc_stack_pkg::UPPER_W-1:0]};
            end
        end
    end

    // pointer: push increments before the write, pop decrements after the read;
    // a full push or empty pop leaves the pointer where it is
    always_comb begin
        sp_nxt = sp_r;
        if (is_push && !push_full) begin
            sp_nxt = sp_r + pc_stack_pkg::SP_ONE; // R10
        end else if (is_pop && !pop_empty) begin
            sp_nxt = sp_r - pc_stack_pkg::SP_ONE; // R11
        end else if (sp_wr) begin
            sp_nxt = sp_wdata; // R13
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sp_r <= pc_stack_pkg::SP_EMPTY; // R12
        end else begin
            sp_r <= sp_nxt;
        end
    end

    // stack write: a call push stores pc_r plus one step, an interrupt push stores pc_r itself, at the incremented slot;
    // software byte writes patch the current top entry
    always_comb begin
        ram_wr    = 1'b0;
        ram_waddr = sp_r;
        ram_wdata = stack_top_entry;
        if (is_push && !push_full) begin
            ram_wr    = 1'b1;
            ram_waddr = sp_nxt; // R10
            ram_wdata = (cmd.op == pc_stack_pkg::OP_IRQ) ? pc_r : pc_r + pc_stack_pkg::PC_STEP; // R10 R21
        end else if (!is_pop && (top_low_wr || top_high_wr || top_upper_wr)) begin
            ram_wr = 1'b1; // R13
            if (top_low_wr) begin
                ram_wdata[pc_stack_pkg::PC_HIGH_LSB-1:0] = top_wdata;
            end
            if (top_high_wr) begin
                ram_wdata[pc_stack_pkg::PC_UPPER_LSB-1:pc_stack_pkg::PC_HIGH_LSB] = top_wdata;
            end
            if (top_upper_wr) begin
                ram_wdata[pc_stack_pkg::PC_W-1:pc_stack_pkg::PC_UPPER_LSB] =
                    top_wdata[pc_stack_pkg::UPPER_W-1:0];
            end
        end
    end

    // storage array separate from program and data space
    return_stack_ram u_ram ( // R8
        .mclk    (mclk),
        .wr_en   (ram_wr),
        .wr_addr (ram_waddr),
        .wr_data (ram_wdata),
        .rd_addr (sp_r),
        .rd_data (stack_top_entry)
    );

    // sticky error flags: power-on or a software clear clears them, a set wins over a software clear
    always_ff @(posedge mclk or posedge por) begin
        if (por) begin
            full_r <= 1'b0;
            unf_r  <= 1'b0;
        end else begin
            if (push_full) begin
                full_r <= 1'b1; // R16 R23
            end else if (full_clr) begin
                full_r <= 1'b0; // R16
            end
            if (pop_empty) begin
                unf_r <= 1'b1; // R16 R23
            end else if (unf_clr) begin
                unf_r <= 1'b0; // R16
            end
        end
    end

    // reset request: set on the same edge as the error flag, held for one cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rst_req_r <= 1'b0;
        end else begin
            rst_req_r <= stack_error_reset_enable && (push_full || pop_empty); // R14 R15
        end
    end

    // shadow stack: one level only, so a nested interrupt overwrites the earlier save
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shadow_r  <= '0;
            restore_r <= 1'b0;
        end else begin
            if (fast_save) begin
                shadow_r <= context_in; // R17 R19 R20
            end
            restore_r <= fast_restore; // R18 R20
        end
    end

    // registered outputs; views follow the state one cycle behind
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fetch_addr            <= pc_stack_pkg::PC_RESET;
            prog_counter_low_byte <= '0;
            high_byte_latch       <= '0;
            upper_byte_latch      <= '0;
            return_stack_pointer  <= pc_stack_pkg::SP_EMPTY;
            stack_top_low         <= '0;
            stack_top_high        <= '0;
            stack_top_upper       <= '0;
        end else begin
            fetch_addr            <= pc_r;
            prog_counter_low_byte <= pc_r[pc_stack_pkg::PC_HIGH_LSB-1:0]; // R2
            high_byte_latch       <= lath_r;
            upper_byte_latch      <= latu_r;
            return_stack_pointer  <= sp_r; // R13
            stack_top_low         <= stack_top_entry[pc_stack_pkg::PC_HIGH_LSB-1:0];
            stack_top_high        <= stack_top_entry[pc_stack_pkg::PC_UPPER_LSB-1:pc_stack_pkg::PC_HIGH_LSB];
            stack_top_upper       <= {3'h0, stack_top_entry[pc_stack_pkg::PC_W-1:pc_stack_pkg::PC_UPPER_LSB]};
        end
    end

    assign stack_full_flag      = full_r;
    assign stack_underflow_flag = unf_r;
    assign stack_reset_req      = rst_req_r;
    assign context_restore      = restore_r;
    assign context_out          = shadow_r;

endmodule

// *** sim/pc_stack_checker.sv ***
// timing relations seen at the top ports
module pc_stack_checker (
    input  wire logic                            mclk,
    input  wire logic                            rst,
    input  wire logic                            por,
    input  wire pc_stack_pkg::seq_cmd_t          cmd,
    input  wire logic                            stack_error_reset_enable,
    input  wire logic                            full_clr,
    input  wire logic [pc_stack_pkg::PC_W-1:0]   fetch_addr,
    input  wire logic [pc_stack_pkg::SP_W-1:0]   return_stack_pointer,
    input  wire logic                            stack_full_flag,
    input  wire logic                            stack_underflow_flag,
    input  wire logic                            stack_reset_req,
    input  wire logic                            context_restore
);
    timeunit 1ns;
    timeprecision 100ps;
    // one domain, so one clock for every property, disabled by rst or por
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst || por);

    // views lag the internal state by one edge, hence the two-cycle delays
    bit0_zero_a: assert property (fetch_addr[0] == 1'b0)
        else $error("fetch address lost word alignment");
    call_push_a: assert property (cmd.op == pc_stack_pkg::OP_CALL && return_stack_pointer != pc_stack_pkg::SP_FULL
        |-> ##2 return_stack_pointer == $past(return_stack_pointer, 2) + 5'h01) else $error("call did not advance pointer");
    call_load_a: assert property (cmd.op == pc_stack_pkg::OP_CALL && return_stack_pointer != pc_stack_pkg::SP_FULL
        |-> ##2 fetch_addr[20:1] == $past(cmd.target[20:1], 2)) else $error("call target not loaded");
    ret_pop_a: assert property (cmd.op == pc_stack_pkg::OP_RETURN && return_stack_pointer != pc_stack_pkg::SP_EMPTY
        |-> ##2 return_stack_pointer == $past(return_stack_pointer, 2) - 5'h01) else $error("return did not drop pointer");
    irq_vector_a: assert property (cmd.op == pc_stack_pkg::OP_IRQ && return_stack_pointer != pc_stack_pkg::SP_FULL
        |-> ##2 fetch_addr == ($past(cmd.irq_high, 2) ? pc_stack_pkg::VEC_HIGH : pc_stack_pkg::VEC_LOW))
        else $error("interrupt vector wrong");
    full_flag_a: assert property (cmd.op == pc_stack_pkg::OP_CALL && return_stack_pointer == pc_stack_pkg::SP_FULL
        |-> ##[1:3] stack_full_flag) else $error("push on full stack not flagged");
    unf_flag_a: assert property (cmd.op == pc_stack_pkg::OP_RETURN && return_stack_pointer == pc_stack_pkg::SP_EMPTY
        |-> ##[1:3] stack_underflow_flag) else $error("pop on empty stack not flagged");
    err_reset_a: assert property ($rose(stack_full_flag) && stack_error_reset_enable
        |-> ##[0:2] stack_reset_req) else $error("stack error did not request reset");
    no_reset_a: assert property (!stack_error_reset_enable && !$past(stack_error_reset_enable)
        |-> !stack_reset_req) else $error("reset requested while disabled");
    flag_sticky_a: assert property (stack_full_flag && !full_clr && !$past(full_clr)
        |=> stack_full_flag) else $error("full flag dropped on its own");
    fast_restore_a: assert property (cmd.op inside {pc_stack_pkg::OP_IRET, pc_stack_pkg::OP_RETURN} && cmd.fast
        |-> ##[1:3] context_restore) else $error("fast return gave no restore strobe");
endmodule

bind program_counter_return_stack pc_stack_checker u_chk (.mclk, .rst, .por, .cmd, .stack_error_reset_enable,
    .full_clr, .fetch_addr, .return_stack_pointer, .stack_full_flag, .stack_underflow_flag, .stack_reset_req,
    .context_restore);

// *** sim/seq_decoder_model.sv ***
// decoder stand-in: one sequencing request per call, held for exactly one taking edge
module seq_decoder_model (
    input  wire logic                mclk,
    output pc_stack_pkg::seq_cmd_t   cmd
);
    timeunit 1ns;
    timeprecision 100ps;
    // launched just after an edge so the taking edge never races the driver
    task automatic issue(input pc_stack_pkg::seq_op_t op, input logic fast, input logic hi,
                         input logic [20:0] tgt);
        @(posedge mclk);
        #1;
        cmd = '{op, fast, hi, 1'b1, tgt};
        @(posedge mclk);
        #1;
        cmd.op = pc_stack_pkg::OP_NONE;
    endtask
    // idle until the bench asks for something
    initial cmd = '0;
endmodule

// *** sim/program_counter_return_stack_tb.sv ***
module program_counter_return_stack_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                    mclk, rst, por, stack_error_reset_enable, full_clr, unf_clr;
    logic                    low_wr, low_rd, lath_wr, latu_wr, sp_wr, top_low_wr, top_high_wr, top_upper_wr;
    logic [7:0]              low_wdata, lat_wdata, top_wdata, prog_counter_low_byte, high_byte_latch;
    logic [7:0]              upper_byte_latch, stack_top_low, stack_top_high, stack_top_upper;
    logic [4:0]              sp_wdata, return_stack_pointer;
    logic [20:0]             fetch_addr;
    logic                    stack_full_flag, stack_underflow_flag, stack_reset_req, context_restore, seen;
    pc_stack_pkg::context_t  context_in, context_out;
    pc_stack_pkg::seq_cmd_t  cmd;
    int                      bad_count, n_checks;

    seq_decoder_model u_dec (.mclk, .cmd);
    program_counter_return_stack u_dut (.mclk, .rst, .por, .cmd, .context_in, .stack_error_reset_enable, .low_wr,
        .low_rd, .low_wdata, .lath_wr, .latu_wr, .lat_wdata, .sp_wr, .sp_wdata, .top_low_wr, .top_high_wr,
        .top_upper_wr, .top_wdata, .full_clr, .unf_clr, .fetch_addr, .prog_counter_low_byte, .high_byte_latch,
        .upper_byte_latch, .return_stack_pointer, .stack_top_low, .stack_top_high, .stack_top_upper,
        .stack_full_flag, .stack_underflow_flag, .stack_reset_req, .context_restore, .context_out);

    // free-running clock, 4 ns period
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // every comparison is counted; a mismatch is reported at once
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            $display("ERROR %0t %s", $time, msg);
            bad_count++;
        end
    endtask
    // one software strobe, one cycle wide, launched off the edge
    task automatic strobe(ref logic s);
        @(posedge mclk);
        #1;
        s = 1'b1;
        @(posedge mclk);
        #1;
        s = 1'b0;
    endtask
    // views settle one edge after the state; two edges give margin
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask
    // watch a one-cycle pulse; it may already stand when the request returns
    task automatic watch(ref logic s);
        seen = s;
        repeat (5) begin
            @(posedge mclk);
            #1;
            seen |= s;
        end
    endtask
    function automatic logic [20:0] top_word();
        return {stack_top_upper[4:0], stack_top_high, stack_top_low};
    endfunction

    task automatic s_sequential();
        chk(fetch_addr === 21'h000000 && return_stack_pointer === 5'h00, "reset state");
        repeat (3) u_dec.issue(pc_stack_pkg::OP_NEXT, 1'b0, 1'b0, 21'h0);
        settle();
        chk(fetch_addr === 21'h000006, "step by two");
    endtask
    task automatic s_call_return();
        u_dec.issue(pc_stack_pkg::OP_CALL, 1'b0, 1'b0, 21'h012344);
        settle();
        chk(fetch_addr === 21'h012344 && return_stack_pointer === 5'h01, "call load");
        chk(top_word() === 21'h000008, "pushed return address");
        u_dec.issue(pc_stack_pkg::OP_RETURN, 1'b0, 1'b0, 21'h0);
        settle();
        chk(fetch_addr === 21'h000008 && return_stack_pointer === 5'h00, "return");
        chk(high_byte_latch === 8'h00 && upper_byte_latch === 8'h00, "latches untouched");
    endtask
    task automatic s_low_byte();
        lat_wdata = 8'h5A;
        strobe(lath_wr);
        lat_wdata = 8'h13;
        strobe(latu_wr);
        low_wdata = 8'h40;
        strobe(low_wr);
        settle();
        chk(fetch_addr === 21'h135A40, "latches copied on low byte write");
        u_dec.issue(pc_stack_pkg::OP_JUMP, 1'b0, 1'b0, 21'h0ABCD0);
        strobe(low_rd);
        settle();
        chk(prog_counter_low_byte === 8'hD0, "low byte view");
        chk(high_byte_latch === 8'hBC && upper_byte_latch === 8'h0A, "read copies upper bytes");
    endtask
    task automatic s_full_underflow();
        stack_error_reset_enable = 1'b1;
        repeat (31) u_dec.issue(pc_stack_pkg::OP_CALL, 1'b0, 1'b0, 21'h000100);
        settle();
        u_dec.issue(pc_stack_pkg::OP_CALL, 1'b0, 1'b0, 21'h000200);
        watch(stack_reset_req);
        chk(seen === 1'b1, "reset request on full");
        chk(stack_full_flag === 1'b1 && return_stack_pointer === 5'h1F, "full refused");
        strobe(full_clr);
        settle();
        chk(stack_full_flag === 1'b0, "software clear");
        stack_error_reset_enable = 1'b0;
        // no interrupt requests are issued while software owns the stack
        sp_wdata = 5'h00;
        strobe(sp_wr);
        u_dec.issue(pc_stack_pkg::OP_RETURN, 1'b0, 1'b0, 21'h0);
        watch(stack_reset_req);
        chk(seen === 1'b0 && stack_underflow_flag === 1'b1, "underflow without reset");
        sp_wdata = 5'h03;
        strobe(sp_wr);
        top_wdata = 8'h34;
        strobe(top_low_wr);
        top_wdata = 8'h12;
        strobe(top_high_wr);
        top_wdata = 8'h01;
        strobe(top_upper_wr);
        settle();
        chk(top_word() === 21'h011234 && return_stack_pointer === 5'h03, "top entry written");
        u_dec.issue(pc_stack_pkg::OP_RETURN, 1'b0, 1'b0, 21'h0);
        u_dec.issue(pc_stack_pkg::OP_EXT_LINK, 1'b0, 1'b0, 21'h0);
        settle();
        chk(fetch_addr === 21'h000102 && return_stack_pointer === 5'h01, "return then link pop");
        strobe(unf_clr);
        settle();
        chk(stack_underflow_flag === 1'b0, "underflow cleared");
    endtask
    task automatic s_shadow();
        context_in = '{5'h15, 8'hA5, 4'h3};
        u_dec.issue(pc_stack_pkg::OP_IRQ, 1'b0, 1'b1, 21'h0);
        settle();
        chk(fetch_addr === 21'h000008 && top_word() === 21'h000102, "high vector, current pc pushed");
        context_in = '{5'h0A, 8'h5C, 4'hC};
        u_dec.issue(pc_stack_pkg::OP_IRQ, 1'b0, 1'b0, 21'h0);
        settle();
        chk(fetch_addr === 21'h000018, "low vector");
        context_in = '{5'h1F, 8'hFF, 4'hF};
        u_dec.issue(pc_stack_pkg::OP_IRET, 1'b1, 1'b0, 21'h0);
        watch(context_restore);
        chk(seen === 1'b1 && context_out === 17'h0A5CC, "nested entry overwrote shadow");
        u_dec.issue(pc_stack_pkg::OP_CALL, 1'b1, 1'b0, 21'h000300);
        context_in = '{5'h03, 8'h3C, 4'h6};
        u_dec.issue(pc_stack_pkg::OP_RETURN, 1'b1, 1'b0, 21'h0);
        watch(context_restore);
        chk(seen === 1'b1 && context_out === 17'h1FFFF, "fast call saved context");
    endtask

    // single closing point for both verdicts
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        wrap_up();
    end
    initial begin
        {rst, por} = 2'b11;
        {stack_error_reset_enable, full_clr, unf_clr, low_wr, low_rd, lath_wr, latu_wr, sp_wr} = '0;
        {top_low_wr, top_high_wr, top_upper_wr, low_wdata, lat_wdata, top_wdata, sp_wdata} = '0;
        context_in = '0;
        bad_count = 0;
        n_checks = 0;
        repeat (2) @(posedge mclk);
        #1;
        {rst, por} = 2'b00;
        s_sequential();
        s_call_return();
        s_low_byte();
        s_full_underflow();
        s_shadow();
        wrap_up();
    end
endmodule
